// >>> src/sdram_pkg.sv
package sdram_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int BANKS  = 4;
  localparam int ROWS   = 2048;
  localparam int COLS   = 256;
  localparam int DATA_W = 32;
  localparam int BANK_W = 2;
  localparam int ROW_W  = 11;
  localparam int COL_W  = 8;
  localparam int LANES  = 4;
  localparam int IDX_W  = BANK_W + ROW_W + COL_W;

  // ---------------------------------------------------------------
  // Commands as {row_strobe_n, col_strobe_n, write_strobe_n}
  // ---------------------------------------------------------------
  typedef logic [2:0] cmd_t;
  localparam cmd_t CMD_LMR = 3'h0;
  localparam cmd_t CMD_REF = 3'h1;
  localparam cmd_t CMD_PRE = 3'h2;
  localparam cmd_t CMD_ACT = 3'h3;
  localparam cmd_t CMD_WR  = 3'h4;
  localparam cmd_t CMD_RD  = 3'h5;
  localparam cmd_t CMD_BST = 3'h6;
  localparam cmd_t CMD_NOP = 3'h7;

  // ---------------------------------------------------------------
  // Address fields and mode settings
  // ---------------------------------------------------------------
  localparam int AP_BIT    = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WB_BIT = 9;
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_2    = 3'h2;
  localparam logic [2:0] CL_3    = 3'h3;
  localparam logic [ROW_W-1:0] MODE_RST = 11'h020;

  // ---------------------------------------------------------------
  // Controller registers
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_WDATA  = 8'h04;
  localparam logic [7:0] OFS_RDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CTRL   = 8'h10;
  localparam int CMDF_BANK_LSB = 11;
  localparam int CMDF_OP_LSB   = 13;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_RVAL_BIT   = 1;
  localparam int CTRL_CKE_BIT  = 0;
  localparam int CTRL_REF_BIT  = 1;
  localparam int CTRL_MASK_LSB = 4;
  localparam logic CKE_RST   = 1'b1;
  localparam logic REFEN_RST = 1'b1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int REF_STD_MS    = 64;
  localparam int REF_EXT_MS    = 16;
  localparam int REF_ROWS      = 4096;
  localparam int REF_STD_CYC   =
    REF_STD_MS * 1000000 / (REF_ROWS * CLK_PERIOD_NS);
  localparam int REF_EXT_CYC   =
    REF_EXT_MS * 1000000 / (REF_ROWS * CLK_PERIOD_NS);

  function automatic cmd_t cmd_of(input logic cs_n, input logic ras_n,
                                  input logic cas_n, input logic we_n);
    return cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
  endfunction

  function automatic logic [DATA_W-1:0] lane_bits(input logic [3:0] en);
    return {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
  endfunction

  function automatic logic [8:0] burst_len(input logic [2:0] code);
    case (code)
      BL_2:    return 9'h002;
      BL_4:    return 9'h004;
      BL_8:    return 9'h008;
      BL_FULL: return 9'h100;
      default: return 9'h001;
    endcase
  endfunction

endpackage

// >>> src/sdram_link_if.sv
`timescale 1ns/1ps
interface sdram_link_if;
  import sdram_pkg::*;

  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BANK_W-1:0] bank_select;
  logic [ROW_W-1:0]  addr_in;
  logic [LANES-1:0]  byte_mask;
  logic [DATA_W-1:0] ctl_dq;
  logic              ctl_dq_oe;
  logic [DATA_W-1:0] dev_dq;
  logic [LANES-1:0]  dev_dq_oe;
  logic [DATA_W-1:0] data_io;

  // Resolved data wire
  assign data_io = (ctl_dq & {DATA_W{ctl_dq_oe}})
                 | (dev_dq & lane_bits(dev_dq_oe));

  modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_select, addr_in,
               byte_mask, data_io, output dev_dq, dev_dq_oe);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select, addr_in,
               byte_mask, ctl_dq, ctl_dq_oe, input data_io, dev_dq_oe);
endinterface

// >>> src/sdram_device.sv
// Notes on behaviour
// - Sample inputs, launch outputs on rising edge
// - Four banks, 2048 rows, 256 columns, 32 bits
// - Activate row before column read or write
// - Activate: bank_select picks bank, addr_in row
// - Column command: addr_in[7:0] is start column
// - Burst length 1,2,4,8,page; stop ends early
// - Burst order sequential or interleaved
// - Read latency two or three cycles
// - Controller refreshes 4096 rows per window
// - Auto precharge closes row after burst, except page-length bursts
// - Precharge other bank while burst continues
// - Burst stop or precharge ends burst
// - Single write mode, reads keep burst
// - New column command accepted every cycle
// - Burst columns generated internally
// - Auto refresh, self refresh, power-down
// - Chip select high ignores commands
// - Bit 10: auto precharge, or all banks
// - Byte masks block writes, float reads
// - Clock gate low: edges invalid, low power
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module sdram_device
  import sdram_pkg::*;
(
  // Clock and reset
  input  wire logic                  I_REF_CLK,
  input  wire logic                  I_RST_N,
  // Link to the controller
  sdram_link_if.dev                  BUS,
  // Status
  output logic                       O_POWER_DOWN,
  output logic                       O_SELF_REFRESH,
  output logic [BANKS-1:0]           O_OPEN_BANKS,
  output logic [ROW_W-1:0]           O_REFRESH_ROW
);
  import sdram_pkg::*;

  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:BANKS*ROWS*COLS-1];
  logic [ROW_W-1:0]  mode_q;
  logic [ROW_W-1:0]  row_q [BANKS];
  logic [BANKS-1:0]  act_q;
  logic [BANKS-1:0]  act_d;
  logic              bst_on_q;
  logic              bst_wr_q;
  logic              bst_ap_q;
  logic              bst_full_q;
  logic              bst_il_q;
  logic [BANK_W-1:0] bst_bank_q;
  logic [ROW_W-1:0]  bst_row_q;
  logic [COL_W-1:0]  bst_start_q;
  logic [8:0]        bst_k_q;
  logic [8:0]        bst_rem_q;
  logic [8:0]        bst_len_q;
  logic              sref_q;
  logic              pdn_q;
  logic [11:0]       sref_tmr_q;
  logic [ROW_W-1:0]  ref_row_q;
  logic [DATA_W-1:0] rd_a_q;
  logic              rd_a_v_q;
  logic [DATA_W-1:0] dq_q;
  logic [LANES-1:0]  oe_q;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  cmd_t              cmd;
  logic              edge_ok;
  logic              is_col;
  logic              col_ok;
  logic              wr_single;
  logic              wr_now;
  logic              step;
  logic              rd_step;
  logic              cl3;
  logic [8:0]        bl;
  logic [COL_W-1:0]  cur_col;
  logic [IDX_W-1:0]  cur_idx;
  logic [IDX_W-1:0]  cmd_idx;
  logic [IDX_W-1:0]  wr_idx;
  logic              ap_end;

  function automatic logic [COL_W-1:0] col_of(
    input logic [COL_W-1:0] start, input logic [COL_W-1:0] k,
    input logic [8:0] len, input logic il);
    logic [COL_W-1:0] m;
    m = len[COL_W-1:0] - 8'h01;
    return (start & ~m) | ((il ? (start ^ k) : (start + k)) & m);
  endfunction

  assign edge_ok = BUS.cke & ~sref_q;
  assign cmd = edge_ok ? cmd_of(BUS.cs_n, BUS.ras_n, BUS.cas_n, BUS.we_n)
                       : CMD_NOP;
  assign bl = burst_len(mode_q[MR_BL_LSB +: 3]);
  assign cl3 = (mode_q[MR_CL_LSB +: 3] == CL_3);
  assign is_col = (cmd == CMD_RD) || (cmd == CMD_WR);
  assign col_ok = is_col && act_q[BUS.bank_select];
  assign wr_single = mode_q[MR_WB_BIT] || (bl == 9'h001);
  assign step = edge_ok && bst_on_q;
  assign rd_step = step && !bst_wr_q;
  assign cur_col = col_of(bst_start_q, bst_k_q[COL_W-1:0], bst_len_q,
                          bst_il_q);
  assign cur_idx = {bst_bank_q, bst_row_q, cur_col};
  assign cmd_idx = {BUS.bank_select, row_q[BUS.bank_select],
                    BUS.addr_in[COL_W-1:0]};
  assign wr_now = (col_ok && cmd == CMD_WR) || (step && bst_wr_q);
  assign wr_idx = (col_ok && cmd == CMD_WR) ? cmd_idx : cur_idx;
  assign ap_end = step && bst_ap_q && !bst_full_q
               && (bst_rem_q == 9'h001);

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      mode_q <= MODE_RST;
    else if (cmd == CMD_LMR)
      mode_q <= BUS.addr_in;
  end

  // ---------------------------------------------------------------
  // Bank rows
  // ---------------------------------------------------------------
  always_comb
  begin
    act_d = act_q;
    if (ap_end)
      act_d[bst_bank_q] = 1'b0;
    if (col_ok && cmd == CMD_WR && wr_single && BUS.addr_in[AP_BIT])
      act_d[BUS.bank_select] = 1'b0;
    if (cmd == CMD_ACT)
      act_d[BUS.bank_select] = 1'b1;
    if (cmd == CMD_PRE)
    begin
      if (BUS.addr_in[AP_BIT])
        act_d = '0;
      else
        act_d[BUS.bank_select] = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      act_q <= '0;
    else
      act_q <= act_d;
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (cmd == CMD_ACT)
      row_q[BUS.bank_select] <= BUS.addr_in;
  end

  // ---------------------------------------------------------------
  // Burst engine
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      bst_on_q    <= 1'b0;
      bst_wr_q    <= 1'b0;
      bst_ap_q    <= 1'b0;
      bst_full_q  <= 1'b0;
      bst_il_q    <= 1'b0;
      bst_bank_q  <= '0;
      bst_row_q   <= '0;
      bst_start_q <= '0;
      bst_k_q     <= '0;
      bst_rem_q   <= '0;
      bst_len_q   <= 9'h001;
    end
    else if (col_ok)
    begin
      bst_wr_q    <= (cmd == CMD_WR);
      bst_on_q    <= !(cmd == CMD_WR && wr_single);
      bst_ap_q    <= BUS.addr_in[AP_BIT];
      bst_full_q  <= (mode_q[MR_BL_LSB +: 3] == BL_FULL);
      bst_il_q    <= mode_q[MR_BT_BIT];
      bst_bank_q  <= BUS.bank_select;
      bst_row_q   <= row_q[BUS.bank_select];
      bst_start_q <= BUS.addr_in[COL_W-1:0];
      bst_len_q   <= bl;
      bst_k_q     <= (cmd == CMD_WR) ? 9'h001 : 9'h000;
      bst_rem_q   <= (cmd == CMD_WR) ? bl - 9'h001 : bl;
    end
    else if (cmd == CMD_BST || (cmd == CMD_PRE
             && (BUS.addr_in[AP_BIT] || BUS.bank_select == bst_bank_q)))
      bst_on_q <= 1'b0;
    else if (step)
    begin
      bst_k_q <= bst_k_q + 9'h001;
      if (!bst_full_q)
      begin
        bst_rem_q <= bst_rem_q - 9'h001;
        if (bst_rem_q == 9'h001)
          bst_on_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Array access
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    for (int g = 0; g < LANES; g++)
    begin
      if (wr_now && !BUS.byte_mask[g])
        mem[wr_idx][g*8 +: 8] <= BUS.data_io[g*8 +: 8];
    end
    if (edge_ok)
    begin
      rd_a_q <= mem[cur_idx];
      dq_q   <= cl3 ? rd_a_q : mem[cur_idx];
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rd_a_v_q <= 1'b0;
      oe_q     <= '0;
    end
    else if (edge_ok)
    begin
      rd_a_v_q <= rd_step;
      oe_q     <= {LANES{cl3 ? rd_a_v_q : rd_step}}
                & ~BUS.byte_mask;
    end
  end

  assign BUS.dev_dq    = dq_q;
  assign BUS.dev_dq_oe = oe_q;

  // ---------------------------------------------------------------
  // Refresh and low power
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sref_q <= 1'b0;
      pdn_q  <= 1'b0;
    end
    else if (BUS.cke)
    begin
      sref_q <= 1'b0;
      pdn_q  <= 1'b0;
    end
    else if (!sref_q && cmd_of(BUS.cs_n, BUS.ras_n, BUS.cas_n,
                                BUS.we_n) == CMD_REF)
    begin
      sref_q <= 1'b1;
      pdn_q  <= 1'b0;
    end
    else if (!sref_q)
      pdn_q <= 1'b1;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sref_tmr_q <= '0;
      ref_row_q  <= '0;
    end
    else if (cmd == CMD_REF)
      ref_row_q <= ref_row_q + 11'h001;
    else if (sref_q)
    begin
      if (sref_tmr_q == 12'(REF_STD_CYC - 1))
      begin
        sref_tmr_q <= '0;
        ref_row_q  <= ref_row_q + 11'h001;
      end
      else
        sref_tmr_q <= sref_tmr_q + 12'h001;
    end
    else
      sref_tmr_q <= '0;
  end

  assign O_POWER_DOWN   = pdn_q;
  assign O_SELF_REFRESH = sref_q;
  assign O_OPEN_BANKS   = act_q;
  assign O_REFRESH_ROW  = ref_row_q;

endmodule

// >>> src/sdram_ctrl.sv
`timescale 1ns/1ps
module sdram_ctrl
  import sdram_pkg::*;
#(
  parameter bit P_EXT_GRADE = 1'b0
)
(
  // Clock and reset
  input  wire logic                  I_REF_CLK,
  input  wire logic                  I_RST_N,
  // Register port
  input  wire logic [7:0]            I_ADDR,
  input  wire logic [DATA_W-1:0]     I_WDATA,
  input  wire logic                  I_WR,
  input  wire logic                  I_RD,
  output logic [DATA_W-1:0]          O_RDATA,
  // Link to the memory
  sdram_link_if.ctl                  BUS
);
  import sdram_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_REF, ST_RD_WAIT} state_e;
  localparam logic [11:0] REF_CYC =
    12'(P_EXT_GRADE ? REF_EXT_CYC : REF_STD_CYC);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_e            state_q;
  logic              cke_q;
  logic              refen_q;
  logic [LANES-1:0]  mask_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rval_q;
  logic              cl3_q;
  logic [1:0]        cnt_q;
  logic [11:0]       tmr_q;
  logic              pend_q;
  logic              cs_n_q;
  cmd_t              op_q;
  logic [BANK_W-1:0] bank_q;
  logic [ROW_W-1:0]  addr_q;
  logic              oe_q;
  logic [DATA_W-1:0] rdo_q;
  logic              busy;
  logic              go;
  logic              fire;
  logic              ref_go;
  logic              cap;
  cmd_t              sw_op;

  assign busy   = (state_q != ST_IDLE) || (pend_q && refen_q);
  assign sw_op  = I_WDATA[CMDF_OP_LSB +: 3];
  assign go     = I_WR && I_ADDR == OFS_CMD && !busy;
  assign fire   = (tmr_q == '0);
  assign ref_go = state_q == ST_IDLE && pend_q && refen_q;
  assign cap    = state_q == ST_RD_WAIT && cnt_q == 2'h0;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cke_q   <= CKE_RST;
      refen_q <= REFEN_RST;
      mask_q  <= '0;
      wdata_q <= '0;
    end
    else if (I_WR && I_ADDR == OFS_CTRL)
    begin
      cke_q   <= I_WDATA[CTRL_CKE_BIT];
      refen_q <= I_WDATA[CTRL_REF_BIT];
      mask_q  <= I_WDATA[CTRL_MASK_LSB +: LANES];
    end
    else if (I_WR && I_ADDR == OFS_WDATA)
      wdata_q <= I_WDATA;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rdo_q <= '0;
    else if (!I_RD)
      rdo_q <= '0;
    else
      case (I_ADDR)
        OFS_WDATA:  rdo_q <= wdata_q;
        OFS_RDATA:  rdo_q <= rdata_q;
        OFS_STATUS: rdo_q <= {30'h0, rval_q, busy};
        OFS_CTRL:   rdo_q <= {24'h0, mask_q, 2'h0, refen_q, cke_q};
        default:    rdo_q <= '0;
      endcase
  end

  assign O_RDATA = rdo_q;

  // ---------------------------------------------------------------
  // Refresh timer
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      tmr_q  <= REF_CYC - 12'h001;
      pend_q <= 1'b0;
    end
    else
    begin
      tmr_q  <= fire ? REF_CYC - 12'h001 : tmr_q - 12'h001;
      pend_q <= fire || (pend_q && state_q != ST_REF);
    end
  end

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_q <= ST_IDLE;
      cs_n_q  <= 1'b1;
      op_q    <= CMD_NOP;
      bank_q  <= '0;
      addr_q  <= '0;
      oe_q    <= 1'b0;
      cnt_q   <= '0;
      cl3_q   <= 1'b0;
    end
    else
    begin
      cs_n_q <= 1'b1;
      op_q   <= CMD_NOP;
      oe_q   <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (ref_go)
          begin
            cs_n_q  <= 1'b0;
            op_q    <= CMD_PRE;
            addr_q  <= 11'h400;
            state_q <= ST_REF;
          end
          else if (go)
          begin
            cs_n_q <= 1'b0;
            op_q   <= sw_op;
            bank_q <= I_WDATA[CMDF_BANK_LSB +: BANK_W];
            addr_q <= I_WDATA[ROW_W-1:0];
            oe_q   <= (sw_op == CMD_WR);
            if (sw_op == CMD_LMR)
              cl3_q <= I_WDATA[MR_CL_LSB +: 3] == CL_3;
            if (sw_op == CMD_RD)
            begin
              cnt_q   <= cl3_q ? 2'h3 : 2'h2;
              state_q <= ST_RD_WAIT;
            end
          end
        ST_REF:
        begin
          cs_n_q  <= 1'b0;
          op_q    <= CMD_REF;
          state_q <= ST_IDLE;
        end
        ST_RD_WAIT:
          if (cnt_q == 2'h0)
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q - 2'h1;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read capture
  // ---------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rdata_q <= '0;
      rval_q  <= 1'b0;
    end
    else
    begin
      if (cap)
        rdata_q <= BUS.data_io & lane_bits(BUS.dev_dq_oe);
      rval_q <= cap || (rval_q && !(I_RD && I_ADDR == OFS_RDATA));
    end
  end

  assign BUS.cke         = cke_q;
  assign BUS.cs_n        = cs_n_q;
  assign BUS.ras_n       = op_q[2];
  assign BUS.cas_n       = op_q[1];
  assign BUS.we_n        = op_q[0];
  assign BUS.bank_select = bank_q;
  assign BUS.addr_in     = addr_q;
  assign BUS.byte_mask   = mask_q;
  assign BUS.ctl_dq      = wdata_q;
  assign BUS.ctl_dq_oe   = oe_q;

endmodule

// >>> test/sdram_link_asserts.sv
`timescale 1ns/1ps
module sdram_link_asserts
  import sdram_pkg::*;
(
  // Clock and reset
  input wire logic             I_REF_CLK,
  input wire logic             I_RST_N,
  // Link
  input wire logic             cke,
  input wire logic             cs_n,
  input wire logic             ras_n,
  input wire logic             cas_n,
  input wire logic             we_n,
  input wire logic [ROW_W-1:0] addr_in,
  input wire logic [LANES-1:0] byte_mask,
  input wire logic             ctl_dq_oe,
  input wire logic [LANES-1:0] dev_dq_oe
);
  // ----------
  // Mode tracking
  // ----------
  cmd_t       cmd;
  logic       rd;
  logic       idle;
  logic [2:0] cl_q;
  logic [2:0] bl_q;

  assign cmd  = cs_n ? CMD_NOP : {ras_n, cas_n, we_n};
  assign rd   = cke && cmd == CMD_RD;
  assign idle = cke && cs_n && byte_mask == 4'h0;

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cl_q <= CL_2;
      bl_q <= BL_1;
    end
    else if (cke && cmd == CMD_LMR)
    begin
      cl_q <= addr_in[MR_CL_LSB +: 3];
      bl_q <= addr_in[MR_BL_LSB +: 3];
    end
  end

  // ----------
  // Checks
  // ----------
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  a_oe_is_write: assert property (ctl_dq_oe == (cmd == CMD_WR))
    else $error("write drive mismatch");
  a_no_drive_clash: assert property (!(ctl_dq_oe && |dev_dq_oe))
    else $error("both ends drive data");
  a_read_cl2: assert property (rd && cl_q == CL_2 ##1 idle
    |=> dev_dq_oe == 4'hF) else $error("latency two missed");
  a_read_cl3: assert property (rd && cl_q == CL_3 ##1 idle[*2]
    |=> dev_dq_oe == 4'hF) else $error("latency three missed");
  a_oe_needs_read: assert property ($rose(|dev_dq_oe)
    |-> $past(rd, 2) || $past(rd, 3)) else $error("data without read");
  a_mask_lanes: assert property ((dev_dq_oe & $past(byte_mask)) == 0)
    else $error("masked lane driven");
  a_single_word: assert property (rd && bl_q == BL_1 ##1 idle[*3]
    |=> dev_dq_oe == 4'h0) else $error("burst too long");
  a_frozen_gate: assert property (!cke |=> $stable(dev_dq_oe))
    else $error("output moved with gate low");

  c_read_cl3: cover property (rd && cl_q == CL_3);
  c_write: cover property (cmd == CMD_WR);
  c_self_ref: cover property (!cke && cmd == CMD_REF);
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import sdram_pkg::*;

  // ----------
  // Bench signals
  // ----------
  logic        clk;
  logic        rst_n;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        pd;
  logic        sr;
  logic [3:0]  open_b;
  logic [10:0] ref_row;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  sdram_link_if link ();

  sdram_ctrl #(.P_EXT_GRADE(1'b1)) sdram_ctrl_i (
    .I_REF_CLK (clk), .I_RST_N (rst_n), .I_ADDR (i_addr),
    .I_WDATA (i_wdata), .I_WR (i_wr), .I_RD (i_rd),
    .O_RDATA (o_rdata), .BUS (link.ctl));
  sdram_device sdram_device_i (
    .I_REF_CLK (clk), .I_RST_N (rst_n), .BUS (link.dev),
    .O_POWER_DOWN (pd), .O_SELF_REFRESH (sr),
    .O_OPEN_BANKS (open_b), .O_REFRESH_ROW (ref_row));
  sdram_link_asserts sdram_link_asserts_i (
    .I_REF_CLK (clk), .I_RST_N (rst_n), .cke (link.cke),
    .cs_n (link.cs_n), .ras_n (link.ras_n), .cas_n (link.cas_n),
    .we_n (link.we_n), .addr_in (link.addr_in),
    .byte_mask (link.byte_mask), .ctl_dq_oe (link.ctl_dq_oe),
    .dev_dq_oe (link.dev_dq_oe));

  // ----------
  // Shared tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge clk);
    i_wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge clk);
    i_rd <= 1'b0;
    @(negedge clk);
    d = o_rdata;
  endtask

  task automatic wait_st(input int b, input logic v);
    logic [31:0] d;
    d = {32{~v}};
    for (int n = 0; n < 40 && d[b] !== v; n++)
      rreg(OFS_STATUS, d);
    chk({31'h0, d[b]}, {31'h0, v});
  endtask

  task automatic cmd(input cmd_t op, input logic [1:0] b,
                     input logic [10:0] a);
    wait_st(ST_BUSY_BIT, 1'b0);
    wreg(OFS_CMD, {16'h0, op, b, a});
  endtask

  task automatic rdw(input logic [10:0] a, input logic [31:0] exp);
    logic [31:0] d;
    cmd(CMD_RD, 2'h2, a);
    wait_st(ST_RVAL_BIT, 1'b1);
    rreg(OFS_RDATA, d);
    chk(d, exp);
  endtask

  task automatic banks(input logic [3:0] exp);
    repeat (2) @(posedge clk);
    chk({28'h0, open_b}, {28'h0, exp});
  endtask

  task automatic modes(input logic [31:0] ctrl, input logic [1:0] exp);
    wreg(OFS_CTRL, ctrl);
    repeat (4) @(posedge clk);
    chk({30'h0, sr, pd}, {30'h0, exp});
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset();
    logic [31:0] d;
    rreg(OFS_CTRL, d);
    chk(d, 32'h3);
    rreg(8'h40, d);
    chk(d, 32'h0);
    chk({21'h0, ref_row}, 32'h0);
    wreg(OFS_CTRL, 32'h1);
    banks(4'h0);
  endtask

  task automatic t_rw();
    cmd(CMD_LMR, 2'h0, 11'h020);
    cmd(CMD_ACT, 2'h2, 11'h5A5);
    banks(4'h4);
    wreg(OFS_WDATA, 32'h1234ABCD);
    cmd(CMD_WR, 2'h2, 11'h033);
    rdw(11'h033, 32'h1234ABCD);
    cmd(CMD_LMR, 2'h0, 11'h030);
    rdw(11'h033, 32'h1234ABCD);
    wreg(OFS_CTRL, 32'h11);
    wreg(OFS_WDATA, 32'h55667788);
    cmd(CMD_WR, 2'h2, 11'h033);
    wreg(OFS_CTRL, 32'h1);
    rdw(11'h033, 32'h556677CD);
    wreg(OFS_CTRL, 32'h21);
    rdw(11'h033, 32'h556600CD);
    wreg(OFS_CTRL, 32'h1);
  endtask

  task automatic t_burst();
    int c;
    cmd(CMD_LMR, 2'h0, 11'h222);
    for (int i = 0; i < 4; i++)
    begin
      wreg(OFS_WDATA, 32'hC0DE0000 + i);
      cmd(CMD_WR, 2'h2, 11'(i));
    end
    for (int t = 0; t < 2; t++)
    begin
      cmd(CMD_LMR, 2'h0, 11'h222 | 11'(t << MR_BT_BIT));
      cmd(CMD_RD, 2'h2, 11'h001);
      repeat (2) @(posedge clk);
      for (int k = 0; k < 4; k++)
      begin
        @(negedge clk);
        c = t ? (1 ^ k) : ((1 + k) & 3);
        chk(link.data_io, 32'hC0DE0000 + c);
      end
    end
  endtask

  task automatic t_pre();
    cmd(CMD_ACT, 2'h1, 11'h001);
    banks(4'h6);
    cmd(CMD_PRE, 2'h1, 11'h000);
    banks(4'h4);
    cmd(CMD_ACT, 2'h3, 11'h002);
    cmd(CMD_RD, 2'h3, 11'h400);
    repeat (10) @(posedge clk);
    banks(4'h4);
    cmd(CMD_PRE, 2'h0, 11'h400);
    banks(4'h0);
  endtask

  task automatic t_refresh();
    logic [10:0] r0;
    int n;
    cmd(CMD_ACT, 2'h0, 11'h010);
    r0 = ref_row;
    wreg(OFS_CTRL, 32'h3);
    for (n = 0; n < 1000 && ref_row === r0; n++)
      @(negedge clk);
    chk({21'h0, ref_row}, {21'h0, r0 + 11'h1});
    chk({28'h0, open_b}, 32'h0);
    for (int p = 0; p < 2; p++)
    begin
      r0 = ref_row;
      for (n = 0; n < 1000 && ref_row === r0; n++)
        @(negedge clk);
    end
    chk(32'(n), 32'(REF_EXT_CYC));
    wreg(OFS_CTRL, 32'h1);
  endtask

  task automatic t_power();
    modes(32'h0, 2'h1);
    modes(32'h1, 2'h0);
    wreg(OFS_CTRL, 32'h0);
    cmd(CMD_REF, 2'h0, 11'h000);
    repeat (4) @(posedge clk);
    chk({30'h0, sr, pd}, 32'h2);
    modes(32'h1, 2'h0);
  endtask

  // ----------
  // Run control
  // ----------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_rw();
    t_burst();
    t_pre();
    t_refresh();
    t_power();
    wrap_up();
  end
endmodule
